// ---- pkg/rtc_pkg.sv ----
// constants, types and helpers shared by the event output and rate trim logic
// assumes one 25 MHz clock; everything slower is an enable pulse
package rtc_pkg;
   localparam int CLK_HZ = 25000000;
   localparam int XTAL_HZ = 32768;
   localparam int EDGE_WIN_US = 7810;
   localparam int EDGE_WIN_CYC = EDGE_WIN_US * (CLK_HZ / 1000000);
   localparam int STAGE_HZ = 16384;
   localparam int HALF_SEC_TICKS = STAGE_HZ / 2;
   localparam int DIV_W = 14;
   localparam logic [5:0] TRIM_LAST_SHORT = 6'h13;
   localparam logic [5:0] TRIM_LAST_LONG = 6'h3B;
   localparam logic [5:0] SEC_LAST = 6'h3B;
   localparam logic [5:0] SEC_HALF = 6'h1E;
   // register offsets
   localparam logic [3:0] ADDR_STATUS1 = 4'h0;
   localparam logic [3:0] ADDR_STATUS2 = 4'h1;
   localparam logic [3:0] ADDR_ALARM1 = 4'h2;
   localparam logic [3:0] ADDR_ALARM2 = 4'h3;
   localparam logic [3:0] ADDR_TRIM = 4'h4;
   // field positions
   localparam int S1_PON_BIT = 0;
   localparam int S1_INIT_BIT = 1;
   localparam int S1_PIN_BIT = 7;
   localparam int S2_A1_BIT = 0;
   localparam int S2_ME_BIT = 1;
   localparam int S2_FE_BIT = 2;
   localparam int S2_XT_BIT = 3;
   localparam int S2_A2_BIT = 4;
   localparam int TRIM_MODE_BIT = 0;
   // reset values: frequency mode at 1 Hz after power-up
   localparam logic [7:0] STATUS2_RST = 8'h04;
   localparam logic [7:0] ALARM1_RST = 8'h01;
   localparam logic [7:0] ALARM2_RST = 8'h00;
   localparam logic [7:0] TRIM_RST = 8'h00;
   localparam logic [7:0] INIT_VAL = 8'h00;

   typedef enum logic [2:0] {
      MODE_OFF, MODE_ALARM1, MODE_FREQ, MODE_EDGE, MODE_PERIOD1, MODE_PERIOD2, MODE_XTAL
   } out_mode_t;

   // signed 7-bit trim value, its lsb held in code bit 7
   function automatic logic [6:0] trim_value(input logic [7:0] code);
      logic [6:0] v;
      v = '0;
      for (int i = 0; i < 7; i++) begin
         v[i] = code[7 - i];
      end
      return v;
   endfunction
endpackage

// ---- pkg/rate_if.sv ----
// carrier between the event output block and the rate trim divider
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface rate_if;
   logic [7:0] trim_code;
   logic [13:0] div_cnt;
   logic stage_tick;
   logic sec_pulse;
   logic xtal_lvl;
   modport trim (input trim_code, output div_cnt, stage_tick, sec_pulse, xtal_lvl);
   modport ctrl (output trim_code, input div_cnt, stage_tick, sec_pulse, xtal_lvl);
endinterface

// ---- design/rate_trim.sv ----
// crystal rate time base with trimmed 16384 Hz divider stage
// assumes the trim code is stable between writes
`timescale 1ns/1ps
module rate_trim import rtc_pkg::*; #(
   parameter int CLK_RATE = CLK_HZ,
   parameter int XTAL_RATE = XTAL_HZ
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   rate_if.trim rif
);
   localparam logic [25:0] STEP = 26'(2 * XTAL_RATE);
   localparam logic [25:0] MODV = 26'(CLK_RATE);

   logic [25:0] acc_q;
   logic [1:0] quarter_q;
   logic [5:0] win_q;
   logic [6:0] pend_q;
   logic sub_q;

   // half-period ticks of the crystal rate by phase accumulation
   wire logic [25:0] acc_sum = acc_q + STEP;
   wire logic half_tick = acc_sum >= MODV;
   wire logic stage_tick = half_tick & (quarter_q == 2'b11);
   wire logic [6:0] tval = trim_value(rif.trim_code);
   wire logic neg = tval[6];
   wire logic [6:0] mag = neg ? 7'(-tval) : tval;
   wire logic [5:0] win_last = rif.trim_code[TRIM_MODE_BIT] ? TRIM_LAST_LONG : TRIM_LAST_SHORT;
   wire logic win_wrap = rif.sec_pulse & (win_q >= win_last);
   // a pending pulse is dropped (step 0) or doubled (step 2) at this stage
   wire logic [1:0] inc = (pend_q != 7'h00) ? (sub_q ? 2'h0 : 2'h2) : 2'h1;
   wire logic [14:0] div_sum = {1'b0, rif.div_cnt} + {13'h0000, inc};

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         acc_q <= 26'h0000000;
         quarter_q <= 2'h0;
         rif.xtal_lvl <= 1'b0;
      end else begin
         acc_q <= half_tick ? 26'(acc_sum - MODV) : acc_sum;
         if (half_tick) begin
            quarter_q <= quarter_q + 2'h1;
            rif.xtal_lvl <= ~rif.xtal_lvl;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rif.div_cnt <= 14'h0000;
         rif.sec_pulse <= 1'b0;
         rif.stage_tick <= 1'b0;
         pend_q <= 7'h00;
         sub_q <= 1'b0;
         win_q <= 6'h00;
      end else begin
         rif.stage_tick <= stage_tick;
         rif.sec_pulse <= stage_tick & div_sum[14];
         if (stage_tick) begin
            rif.div_cnt <= div_sum[13:0];
            if (pend_q != 7'h00) begin
               pend_q <= pend_q - 7'h01;
            end
         end
         if (rif.sec_pulse) begin
            win_q <= win_wrap ? 6'h00 : win_q + 6'h01;
         end
         if (win_wrap) begin
            pend_q <= mag;
            sub_q <= neg;
         end
      end
   end
endmodule // rate_trim

// ---- design/rtc_event_out.sv ----
// event output pin logic, output modes and register port of the clock
// assumes alarm match and data read/write strobes come from logic on i_clk
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module rtc_event_out import rtc_pkg::*; #(
   parameter int CLK_RATE = CLK_HZ,
   parameter int XTAL_RATE = XTAL_HZ,
   parameter int EDGE_WIN_CYCLES = EDGE_WIN_CYC
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic i_alarm1_match,
   input wire logic i_alarm2_match,
   input wire logic i_rtd_read,
   input wire logic i_rtd_write,
   input wire logic [5:0] i_rtd_sec,
   output logic o_minute_carry,
   output logic o_event_n
);
   rate_if rif();

   logic pon_q;
   logic [7:0] st2_q;
   logic [7:0] alarm1_q;
   logic [7:0] alarm2_q;
   logic [7:0] trim_q;
   logic [5:0] sec_q;
   logic carry_pend_q;
   logic [13:0] hold_q;
   logic [17:0] win_cnt_q;
   logic a1_prev_q;
   logic a2_prev_q;
   logic a1_low_q;
   logic a2_low_q;
   logic edge_lat_q;
   logic p1_seen_q;
   logic p2_seen_q;

   rate_trim #(
      .CLK_RATE(CLK_RATE),
      .XTAL_RATE(XTAL_RATE)
   ) u_trim (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .rif(rif.trim)
   );

   assign rif.trim_code = trim_q;

   // register port decode
   wire logic wr_s1 = i_wr & (i_addr == ADDR_STATUS1);
   wire logic init = wr_s1 & i_wdata[S1_INIT_BIT];
   wire logic wr_s2 = i_wr & (i_addr == ADDR_STATUS2);
   wire logic wr_a1 = i_wr & (i_addr == ADDR_ALARM1);
   wire logic wr_a2 = i_wr & (i_addr == ADDR_ALARM2);
   wire logic wr_tr = i_wr & (i_addr == ADDR_TRIM);
   wire logic [7:0] s1_view = {o_event_n, 6'h00, pon_q};
   wire logic [7:0] rd_mux = (i_addr == ADDR_STATUS1) ? s1_view :
                             (i_addr == ADDR_STATUS2) ? st2_q :
                             (i_addr == ADDR_ALARM1) ? alarm1_q :
                             (i_addr == ADDR_ALARM2) ? alarm2_q :
                             (i_addr == ADDR_TRIM) ? trim_q : 8'h00;

   // output mode decode from the enable bits
   wire logic en_a1 = st2_q[S2_A1_BIT];
   wire logic en_me = st2_q[S2_ME_BIT];
   wire logic en_fe = st2_q[S2_FE_BIT];
   wire logic en_xt = st2_q[S2_XT_BIT];
   wire logic en_a2 = st2_q[S2_A2_BIT];
   out_mode_t mode;
   assign mode = en_xt ? MODE_XTAL :
                 (en_me & ~en_fe) ? MODE_EDGE :
                 (en_me & en_fe & ~en_a1) ? MODE_PERIOD1 :
                 (en_me & en_fe & en_a1) ? MODE_PERIOD2 :
                 en_fe ? MODE_FREQ :
                 en_a1 ? MODE_ALARM1 : MODE_OFF;
   wire logic mode_a1 = mode == MODE_ALARM1;
   wire logic mode_freq = mode == MODE_FREQ;
   wire logic mode_edge = mode == MODE_EDGE;
   wire logic mode_p1 = mode == MODE_PERIOD1;
   wire logic mode_p2 = mode == MODE_PERIOD2;
   wire logic mode_xt = mode == MODE_XTAL;

   // seconds count and minute carry, held off for up to 0.5 s while data is being read
   wire logic sec_wrap = rif.sec_pulse & (sec_q >= SEC_LAST);
   wire logic hold_done = hold_q >= 14'(HALF_SEC_TICKS - 1);
   wire logic carry_go = carry_pend_q & (~i_rtd_read | hold_done);
   wire logic carry = o_minute_carry;
   wire logic win_on = win_cnt_q != 18'h00000;
   wire logic [5:0] sec_load = (i_rtd_sec > SEC_LAST) ? 6'h00 : i_rtd_sec;

   // per-source low requests
   wire logic a1_rise = i_alarm1_match & ~a1_prev_q;
   wire logic a2_rise = i_alarm2_match & ~a2_prev_q;
   logic [7:0] waves;
   always_comb begin
      waves = 8'h00;
      for (int k = 0; k < 8; k++) begin
         waves[k] = rif.div_cnt[DIV_W - 1 - k];
      end
   end
   wire logic freq_high = &(waves | ~alarm1_q);
   wire logic freq_low = mode_freq & (|alarm1_q) & ~freq_high;
   wire logic xtal_low = mode_xt & ~rif.xtal_lvl;
   wire logic edge_low = edge_lat_q | (mode_edge & win_on);
   wire logic p1_low = mode_p1 & p1_seen_q & (sec_q < SEC_HALF);
   wire logic p2_low = p2_seen_q & win_on;
   wire logic any_low = a1_low_q | a2_low_q | freq_low | xtal_low | edge_low | p1_low | p2_low;

   // registers written by software
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pon_q <= 1'b1;
         st2_q <= STATUS2_RST;
         alarm1_q <= ALARM1_RST;
         alarm2_q <= ALARM2_RST;
         trim_q <= TRIM_RST;
      end else if (init) begin
         pon_q <= 1'b0;
         st2_q <= INIT_VAL;
         alarm1_q <= INIT_VAL;
         alarm2_q <= INIT_VAL;
         trim_q <= INIT_VAL;
      end else begin
         if (wr_s2) begin
            st2_q <= i_wdata;
         end
         if (wr_a1) begin
            alarm1_q <= i_wdata;
         end
         if (wr_a2) begin
            alarm2_q <= i_wdata;
         end
         if (wr_tr) begin
            trim_q <= i_wdata;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_rdata <= 8'h00;
      end else begin
         o_rdata <= i_rd ? rd_mux : 8'h00;
      end
   end

   // seconds, postponed minute carry and the 7.81 ms window
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sec_q <= 6'h00;
         carry_pend_q <= 1'b0;
         hold_q <= 14'h0000;
         o_minute_carry <= 1'b0;
      end else begin
         if (i_rtd_write) begin
            sec_q <= sec_load;
         end else if (rif.sec_pulse) begin
            sec_q <= sec_wrap ? 6'h00 : sec_q + 6'h01;
         end
         o_minute_carry <= carry_go;
         if (sec_wrap) begin
            carry_pend_q <= 1'b1;
         end else if (carry_go) begin
            carry_pend_q <= 1'b0;
         end
         if (!carry_pend_q || carry_go) begin
            hold_q <= 14'h0000;
         end else if (rif.stage_tick && !hold_done) begin
            hold_q <= hold_q + 14'h0001;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         win_cnt_q <= 18'h00000;
      end else if (carry) begin
         win_cnt_q <= 18'(EDGE_WIN_CYCLES);
      end else if (win_on) begin
         win_cnt_q <= win_cnt_q - 18'h00001;
      end
   end

   // alarm latches: a new low needs a match start or a minute carry
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         a1_prev_q <= 1'b0;
         a2_prev_q <= 1'b0;
         a1_low_q <= 1'b0;
         a2_low_q <= 1'b0;
      end else begin
         a1_prev_q <= i_alarm1_match;
         a2_prev_q <= i_alarm2_match;
         a1_low_q <= mode_a1 & (a1_low_q | (i_alarm1_match & (a1_rise | carry)));
         a2_low_q <= en_a2 & (a2_low_q | (i_alarm2_match & (a2_rise | carry)));
      end
   end

   // minute modes start only at a carry seen in that mode, except edge mode, also low in a running window, and period1, which keeps a carry until init
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         edge_lat_q <= 1'b0;
         p1_seen_q <= 1'b0;
         p2_seen_q <= 1'b0;
      end else begin
         edge_lat_q <= mode_edge & (edge_lat_q | carry);
         if (carry && mode_p1) begin
            p1_seen_q <= 1'b1;
         end else if (init) begin
            p1_seen_q <= 1'b0;
         end
         p2_seen_q <= mode_p2 & (p2_seen_q | carry);
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_event_n <= 1'b1;
      end else begin
         o_event_n <= ~any_low;
      end
   end
endmodule // rtc_event_out

// ---- sim/rtc_event_out_asserts.sv ----
// assertions on the event pin and register port of the clock
// assumes a host that keeps the register bus rules
`timescale 1ns/1ps
module rtc_event_out_asserts import rtc_pkg::*; (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input logic [7:0] o_rdata,
   input wire logic i_alarm2_match,
   input logic o_minute_carry,
   input logic o_event_n
);
   logic [7:0] s2_q;
   logic pon_q;
   wire s2_wr = i_wr && i_addr == ADDR_STATUS2;
   wire init_w = i_wr && i_addr == ADDR_STATUS1 && i_wdata[S1_INIT_BIT];
   wire edge_w = s2_q[S2_ME_BIT] && !s2_q[S2_FE_BIT] && !s2_q[S2_XT_BIT];
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         s2_q <= STATUS2_RST;
         pon_q <= 1'b1;
      end else if (init_w) begin
         s2_q <= 8'h00;
         pon_q <= 1'b0;
      end else if (s2_wr) begin
         s2_q <= i_wdata;
      end
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   pon_read_a: assert property (
      i_rd && i_addr == ADDR_STATUS1 |=> o_rdata[S1_PON_BIT] == $past(pon_q))
      else $error("power-on flag read wrong");
   power_low_a: assert property (
      $rose(i_reset_n) |-> ##[1:16] !o_event_n) else $error("no 1 Hz low after power-up");
   status2_read_a: assert property (
      i_rd && i_addr == ADDR_STATUS2 |=> o_rdata == $past(s2_q)) else $error("status2 read wrong");
   pin_read_a: assert property (
      i_rd && i_addr == ADDR_STATUS1 |=> o_rdata[S1_PIN_BIT] == $past(o_event_n))
      else $error("pin level read wrong");
   edge_low_a: assert property (
      o_minute_carry && edge_w && !i_wr |-> ##2 !o_event_n) else $error("edge mode not low");
   alarm2_low_a: assert property (
      $rose(i_alarm2_match) && s2_q[S2_A2_BIT] && !i_wr |-> ##[1:2] !o_event_n)
      else $error("second alarm not low");
   rearm_quiet_a: assert property (
      s2_wr && i_wdata == 8'h10 && s2_q == 8'h00 && i_alarm2_match && $past(i_alarm2_match)
      ##1 !o_minute_carry |=> o_event_n) else $error("rearm lowered pin");
   release_a: assert property (
      s2_wr && i_wdata == 8'h00 ##1 !i_wr [*2] |=> o_event_n [*2]) else $error("pin not released");
endmodule // rtc_event_out_asserts
bind rtc_event_out rtc_event_out_asserts u_asserts (.i_clk(i_clk), .i_reset_n(i_reset_n),
   .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
   .i_alarm2_match(i_alarm2_match), .o_minute_carry(o_minute_carry), .o_event_n(o_event_n));

// ---- sim/event_monitor.sv ----
// host-side monitor counting cycles with the event pin released
// assumes the host samples the pin on the same clock
`timescale 1ns/1ps
module event_monitor (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_clear,
   input wire logic i_event_n,
   output logic [31:0] o_high_cycles
);
   // active low pin: high means no source is asserting
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_high_cycles <= 32'h0;
      end else if (i_clear) begin
         o_high_cycles <= 32'h0;
      end else begin
         o_high_cycles <= o_high_cycles + {31'h0, i_event_n};
      end
   end
endmodule // event_monitor

// ---- sim/tb.sv ----
// self-checking bench for the event pin and register port
// assumes a raised crystal rate so that one second fits the run
`timescale 1ns/1ps
module tb;
   import rtc_pkg::*;
   localparam int N = 6000;
   // data read spans the first seconds wrap and ends well before the 0.5 s hold runs out
   localparam int T_READ = 45000;
   logic i_clk, i_reset_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, clr = 1'b0, o_minute_carry, o_event_n;
   logic i_alarm1_match = 1'b0, i_alarm2_match = 1'b0, i_rtd_read = 1'b0, i_rtd_write = 1'b0;
   logic [3:0] i_addr = 4'h0;
   logic [7:0] i_wdata = 8'h00, o_rdata;
   logic [5:0] i_rtd_sec = 6'h00;
   logic [31:0] hi;
   logic [7:0] tbl [5] = '{8'h00, 8'h56, 8'hD8, 8'h01, 8'h00};
   logic [7:0] sel [4] = '{8'h80, 8'hC0, 8'h00, 8'h00};
   int n_errors = 0, n_checks = 0, seed = 54, w = 0;
   rtc_event_out #(.XTAL_RATE(12000000), .EDGE_WIN_CYCLES(50)) i_dut (.i_clk(i_clk),
      .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(o_rdata), .i_alarm1_match(i_alarm1_match), .i_alarm2_match(i_alarm2_match),
      .i_rtd_read(i_rtd_read), .i_rtd_write(i_rtd_write), .i_rtd_sec(i_rtd_sec),
      .o_minute_carry(o_minute_carry), .o_event_n(o_event_n));
   event_monitor i_mon (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_clear(clr),
      .i_event_n(o_event_n), .o_high_cycles(hi));
   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: saw %0h want %0h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= v;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 check({24'h0, o_rdata & m}, {24'h0, e});
   endtask
   task automatic pin(input logic e);
      repeat (3) @(posedge i_clk);
      #1 check({31'h0, o_event_n}, {31'h0, e});
   endtask
   // released share of the window: each selected wave halves it
   function automatic logic ok_duty(input logic [31:0] h, input logic [7:0] s);
      int e;
      e = N >> $countones(s);
      return (h > e - N / 16) && (h < e + N / 16);
   endfunction
   initial begin
      tbl[4] = 8'($random(seed)) & 8'h7F;
      sel[2] = 8'($random(seed)) & 8'hE0;
      repeat (2) @(posedge i_clk);
      i_reset_n <= 1'b1;
      repeat (4) @(posedge i_clk);
      #1 check({31'h0, o_event_n}, 32'h0);
      rd(ADDR_STATUS1, 8'h01, 8'h01);
      rd(ADDR_STATUS2, 8'hFF, STATUS2_RST);
      rd(ADDR_ALARM1, 8'hFF, ALARM1_RST);
      wr(ADDR_STATUS1, 8'h02);
      rd(ADDR_STATUS1, 8'h01, 8'h00);
      rd(ADDR_STATUS2, 8'hFF, 8'h00);
      for (int a = 5; a < 16; a++) begin
         wr(4'(a), 8'hFF);
         rd(4'(a), 8'hFF, 8'h00);
      end
      foreach (tbl[k]) begin
         wr(ADDR_TRIM, tbl[k]);
         rd(ADDR_TRIM, 8'hFF, tbl[k]);
      end
      wr(ADDR_STATUS2, 8'h04);
      foreach (sel[k]) begin
         wr(ADDR_ALARM1, sel[k]);
         @(posedge i_clk);
         clr <= 1'b1;
         @(posedge i_clk);
         clr <= 1'b0;
         repeat (N) @(posedge i_clk);
         #1 check({31'h0, ok_duty(hi, sel[k])}, 32'h1);
      end
      // crystal mode: the pin follows a square wave, high half the time
      wr(ADDR_STATUS2, 8'h08);
      @(posedge i_clk);
      clr <= 1'b1;
      @(posedge i_clk);
      clr <= 1'b0;
      repeat (N) @(posedge i_clk);
      #1 check({31'h0, ok_duty(hi, 8'h01)}, 32'h1);
      wr(ADDR_STATUS2, 8'h01);
      i_alarm1_match <= 1'b1;
      pin(1'b0);
      wr(ADDR_STATUS2, 8'h00);
      pin(1'b1);
      wr(ADDR_STATUS2, 8'h01);
      pin(1'b1);
      i_alarm1_match <= 1'b0;
      wr(ADDR_STATUS2, 8'h14);
      i_alarm2_match <= 1'b1;
      pin(1'b0);
      wr(ADDR_STATUS2, 8'h00);
      pin(1'b1);
      wr(ADDR_STATUS2, 8'h10);
      pin(1'b1);
      wr(ADDR_STATUS2, 8'h12);
      i_rtd_sec <= SEC_LAST;
      i_rtd_write <= 1'b1;
      i_rtd_read <= 1'b1;
      @(posedge i_clk);
      i_rtd_write <= 1'b0;
      repeat (T_READ) begin
         @(posedge i_clk);
         #1;
         if (o_minute_carry === 1'b1) break;
      end
      check({31'h0, o_minute_carry}, 32'h0);
      i_rtd_read <= 1'b0;
      repeat (8) begin
         @(posedge i_clk);
         #1;
         w++;
         if (o_minute_carry === 1'b1) break;
      end
      check({31'h0, o_minute_carry}, 32'h1);
      check(32'(w), 32'h1);
      repeat (2) @(posedge i_clk);
      #1 check({31'h0, o_event_n}, 32'h0);
      wr(ADDR_STATUS2, 8'h10);
      pin(1'b0);
      wr(ADDR_STATUS2, 8'h00);
      pin(1'b1);
      wr(ADDR_STATUS2, 8'h02);
      pin(1'b0);
      wr(ADDR_STATUS2, 8'h00);
      pin(1'b1);
      finish_test();
   end
   initial begin
      repeat (100000) @(posedge i_clk);
      n_errors++;
      finish_test();
   end
endmodule // tb
